// ### logic/wpc_pkg.sv
/*
 * wpc_pkg: constants, register map and state type of the path overhead
 * and performance counter block.
 * assumes: a 40 MHz main clock; the receive path runs on that clock.
 */
`default_nettype none

package wpc_pkg;

	// ----------------------------------------------------------------
	// clock and defect timing
	// ----------------------------------------------------------------
	localparam int CLK_HZ = 40000000;
	localparam int LOSS_SET_TIME_US = 3000;
	localparam int LOSS_CLR_TIME_US = 1000;
	localparam int LOSS_SET_CYC = (CLK_HZ / 1000000) * LOSS_SET_TIME_US;
	localparam int LOSS_CLR_CYC = (CLK_HZ / 1000000) * LOSS_CLR_TIME_US;

	// ----------------------------------------------------------------
	// register byte addresses
	// ----------------------------------------------------------------
	localparam logic [7:0] ADDR_TXOH = 8'h00;
	localparam logic [7:0] ADDR_CFG = 8'h04;
	localparam logic [7:0] ADDR_CTRL = 8'h08;
	localparam logic [7:0] ADDR_PERIOD = 8'h0C;
	localparam logic [7:0] ADDR_MASK = 8'h10;
	localparam logic [7:0] ADDR_STATUS = 8'h14;
	localparam logic [7:0] ADDR_STD = 8'h20;
	localparam logic [7:0] ADDR_STAT = 8'h48;
	localparam int NCNT = 5;

	// ----------------------------------------------------------------
	// field positions
	// ----------------------------------------------------------------
	localparam int CTRL_FORCE = 0;
	localparam int CTRL_EN = 1;
	localparam int CTRL_SRC = 2;
	localparam int MASK_DA = 0;
	localparam int MASK_DB = 1;
	localparam int MASK_SA = 2;
	localparam int MASK_SB = 3;
	localparam int ST_LAT = 0;
	localparam int ST_DPEND = 1;
	localparam int ST_SPEND = 2;
	localparam int ST_DEFECT = 3;

	// ----------------------------------------------------------------
	// reset values
	// ----------------------------------------------------------------
	localparam logic [23:0] TXOH_RST = 24'h000000;
	localparam logic [3:0] CFG_RST = 4'h0;
	localparam logic [31:0] PERIOD_RST = 32'h02625A00;

	typedef struct packed {
		logic [23:0] txoh;
		logic [3:0] cfg;
		logic en;
		logic src;
		logic force_p;
		logic [31:0] period;
		logic [3:0] mask;
		logic lat;
		logic dpend;
		logic spend;
		logic defect;
		logic [31:0] dcnt;
		logic lost_q;
		logic [31:0] tmr;
		logic [2:0] gsync;
		logic glvl;
		logic tick_q;
		logic [NCNT-1:0][31:0] std_live;
		logic [NCNT-1:0][31:0] std_hold;
		logic [NCNT-1:0][31:0] stat_live;
		logic [NCNT-1:0][31:0] stat_snap;
		logic [31:0] rdata;
		logic err;
	} wpc_state_s;

endpackage

`default_nettype wire

// ### logic/wpc_top.sv
/*
 * wpc_top: path overhead insertion values, delineation loss tracking and
 * standard plus statistical error counters, behind an APB slave.
 * assumes: frame error inputs and the PCS alarm are on mclk_i; the tick
 * gpio is asynchronous.
 */
// Function
// R1: transmit programmable Z3 and Z4 growth octets, zero by default.
// R2: transmit programmable N1 data channel octet, zero by default.
// R3: PCS delineation loss sets latched status and pending bit, maskable to two irqs.
// R4: back-report delineation loss once lost continuously over 3 ms.
// R5: after reset back-report loss until PCS delineates again.
// R6: drop defect only after condition absent at least 1 ms.
// R7: each error count has a standard and a statistical counter.
// R8: reading upper standard half copies live count into both halves.
// R9: reading lower standard half returns the half captured earlier.
// R10: manager reads upper standard half before lower half.
// R11: tick copies all statistical counters at once, then clears them.
// R12: force bit makes a tick regardless of enable.
// R13: internal source with enable gives periodic ticks from period count.
// R14: gpio source with enable ticks on each gpio rising edge.
// R15: every tick sets pending bit, maskable to two irqs.
// R16: statistical counters saturate instead of wrapping.
// R17: count B1, B2, B3, far path and far line errors at given rates.
// R18: block bit low adds one per mismatched parity bit.
// R19: block bit high adds one per frame with any mismatch.
// R20: software polls often enough to avoid saturation.
// R21: far path counter may also count in block mode.
// R22: gpio is synchronised before edge detection, one tick per edge.
// R23: force bit is a self-clearing pulse.
`timescale 1ns/1ps
`default_nettype none

module wpc_top #(
	parameter int SET_CYC = wpc_pkg::LOSS_SET_CYC,
	parameter int CLR_CYC = wpc_pkg::LOSS_CLR_CYC
) (
	// clock and reset
	input wire logic mclk_i,
	input wire logic rst_n_i,
	// apb slave
	input wire logic psel_i,
	input wire logic penable_i,
	input wire logic pwrite_i,
	input wire logic [7:0] paddr_i,
	input wire logic [31:0] pwdata_i,
	output logic [31:0] prdata_o,
	output logic pready_o,
	output logic pslverr_o,
	// receive frame errors
	input wire logic frame_valid_i,
	input wire logic [3:0] section_parity_mismatch_i,
	input wire logic [10:0] line_parity_mismatch_i,
	input wire logic [3:0] path_parity_mismatch_i,
	input wire logic [3:0] far_path_errors_i,
	input wire logic [10:0] far_line_errors_i,
	// pcs and gpio
	input wire logic pcs_delineation_lost_i,
	input wire logic snapshot_gpio_i,
	// transmit overhead and status
	output logic [7:0] tx_path_growth_octet_a_o,
	output logic [7:0] tx_path_growth_octet_b_o,
	output logic [7:0] tx_path_data_channel_octet_o,
	output logic path_delineation_loss_o,
	output logic perf_snapshot_tick_o,
	output logic wan_irq_out_a_o,
	output logic wan_irq_out_b_o
);

	// ----------------------------------------------------------------
	// reset release
	// ----------------------------------------------------------------
	logic [1:0] rst_sync_q;
	logic rst_n;

	always_ff @(posedge mclk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			rst_sync_q <= 2'h0;
		end else begin
			rst_sync_q <= {rst_sync_q[0], 1'b1};
		end
	end
	assign rst_n = rst_sync_q[1];

	// ----------------------------------------------------------------
	// next state
	// ----------------------------------------------------------------
	wpc_pkg::wpc_state_s q, d;
	logic setup, acc, wr, rd_status, tick, itick, gedge, lost;
	logic [wpc_pkg::NCNT-1:0][10:0] err_in;
	logic [wpc_pkg::NCNT-1:0][31:0] add;
	logic [wpc_pkg::NCNT-1:0] blk;
	logic [32:0] sum;
	logic [7:0] off;
	logic [2:0] idx;

	always_comb begin
		d = q;
		setup = psel_i & ~penable_i;
		acc = psel_i & penable_i;
		wr = acc & pwrite_i;
		rd_status = acc & ~pwrite_i & (paddr_i == wpc_pkg::ADDR_STATUS);
		off = 8'h0;
		idx = 3'h0;
		d.force_p = 1'b0;
		if (wr) begin
			case (paddr_i)
				wpc_pkg::ADDR_TXOH: d.txoh = pwdata_i[23:0]; // R1 R2
				wpc_pkg::ADDR_CFG: d.cfg = pwdata_i[3:0];
				wpc_pkg::ADDR_CTRL: begin
					d.force_p = pwdata_i[wpc_pkg::CTRL_FORCE]; // R23
					d.en = pwdata_i[wpc_pkg::CTRL_EN];
					d.src = pwdata_i[wpc_pkg::CTRL_SRC];
				end
				wpc_pkg::ADDR_PERIOD: d.period = pwdata_i;
				wpc_pkg::ADDR_MASK: d.mask = pwdata_i[3:0];
				default: ;
			endcase
		end

		// gpio: three stages, a change counts when the last two agree
		d.gsync = {q.gsync[1:0], snapshot_gpio_i}; // R22
		gedge = 1'b0;
		if (q.gsync[2] == q.gsync[1]) begin
			d.glvl = q.gsync[2];
			gedge = q.gsync[2] & ~q.glvl; // R22
		end

		// periodic timer
		itick = 1'b0;
		if (q.en & q.src) begin
			if (q.tmr + 32'h1 >= q.period) begin
				itick = 1'b1; // R13
				d.tmr = 32'h0;
			end else begin
				d.tmr = q.tmr + 32'h1;
			end
		end else begin
			d.tmr = 32'h0;
		end
		tick = q.force_p | itick | (q.en & ~q.src & gedge); // R12 R14
		d.tick_q = tick;

		// per-frame increments
		err_in[0] = {7'h0, section_parity_mismatch_i}; // R17
		err_in[1] = line_parity_mismatch_i;
		err_in[2] = {7'h0, path_parity_mismatch_i};
		err_in[3] = {7'h0, far_path_errors_i};
		err_in[4] = far_line_errors_i;
		blk = {1'b0, q.cfg}; // R21
		for (int i = 0; i < wpc_pkg::NCNT; i++) begin
			add[i] = 32'h0;
			if (frame_valid_i) begin
				if (blk[i]) begin
					add[i] = {31'h0, |err_in[i]}; // R19
				end else begin
					add[i] = {21'h0, err_in[i]}; // R18
				end
			end
			d.std_live[i] = q.std_live[i] + add[i]; // R7
			sum = {1'b0, q.stat_live[i]} + {1'b0, add[i]};
			if (tick) begin
				d.stat_snap[i] = q.stat_live[i]; // R11
				d.stat_live[i] = add[i];
			end else if (sum[32]) begin
				d.stat_live[i] = 32'hFFFFFFFF; // R16
			end else begin
				d.stat_live[i] = sum[31:0];
			end
		end

		// delineation loss qualification
		lost = pcs_delineation_lost_i;
		d.lost_q = lost;
		if (lost == q.defect) begin
			d.dcnt = 32'h0;
		end else if (lost && q.dcnt == 32'(SET_CYC)) begin
			d.defect = 1'b1; // R4
			d.dcnt = 32'h0;
		end else if (!lost && q.dcnt == 32'(CLR_CYC - 1)) begin
			d.defect = 1'b0; // R5 R6
			d.dcnt = 32'h0;
		end else begin
			d.dcnt = q.dcnt + 32'h1;
		end

		// sticky bits: only bits returned as one are cleared, sets win
		d.lat = (q.lat & ~(rd_status & q.rdata[wpc_pkg::ST_LAT])) | lost; // R3
		d.dpend = (q.dpend & ~(rd_status & q.rdata[wpc_pkg::ST_DPEND])) | (lost & ~q.lost_q); // R3
		d.spend = (q.spend & ~(rd_status & q.rdata[wpc_pkg::ST_SPEND])) | tick; // R15

		// read data and latching happen in the setup cycle
		if (setup) begin
			d.rdata = 32'h0;
			d.err = 1'b0;
			off = 8'(paddr_i - wpc_pkg::ADDR_STD);
			idx = off[5:3];
			case (paddr_i)
				wpc_pkg::ADDR_TXOH: d.rdata = {8'h0, q.txoh};
				wpc_pkg::ADDR_CFG: d.rdata = {28'h0, q.cfg};
				wpc_pkg::ADDR_CTRL: d.rdata = {29'h0, q.src, q.en, 1'b0};
				wpc_pkg::ADDR_PERIOD: d.rdata = q.period;
				wpc_pkg::ADDR_MASK: d.rdata = {28'h0, q.mask};
				wpc_pkg::ADDR_STATUS: d.rdata = {28'h0, q.defect, q.spend, q.dpend, q.lat};
				default: begin
					if (paddr_i[1:0] != 2'h0) begin
						d.err = 1'b1;
					end else if (paddr_i >= wpc_pkg::ADDR_STD && paddr_i < wpc_pkg::ADDR_STAT) begin
						if (off[2]) begin
							d.rdata = {16'h0, q.std_hold[idx][15:0]}; // R9
						end else begin
							d.rdata = {16'h0, q.std_live[idx][31:16]}; // R8
							if (!pwrite_i) begin
								d.std_hold[idx] = q.std_live[idx]; // R8
							end
						end
					end else if (paddr_i >= wpc_pkg::ADDR_STAT &&
						paddr_i < 8'(wpc_pkg::ADDR_STAT + 8'(4 * wpc_pkg::NCNT))) begin
						off = 8'(paddr_i - wpc_pkg::ADDR_STAT);
						d.rdata = q.stat_snap[off[4:2]];
					end else begin
						d.err = 1'b1;
					end
				end
			endcase
		end
	end

	// ----------------------------------------------------------------
	// state register
	// ----------------------------------------------------------------
	always_ff @(posedge mclk_i or negedge rst_n) begin
		if (!rst_n) begin
			q <= '0;
			q.txoh <= wpc_pkg::TXOH_RST;
			q.cfg <= wpc_pkg::CFG_RST;
			q.period <= wpc_pkg::PERIOD_RST;
			q.defect <= 1'b1;
		end else begin
			q <= d;
		end
	end

	// ----------------------------------------------------------------
	// outputs
	// ----------------------------------------------------------------
	assign prdata_o = q.rdata;
	assign pready_o = psel_i & penable_i;
	assign pslverr_o = psel_i & penable_i & q.err;
	assign tx_path_growth_octet_a_o = q.txoh[7:0];
	assign tx_path_growth_octet_b_o = q.txoh[15:8];
	assign tx_path_data_channel_octet_o = q.txoh[23:16];
	assign path_delineation_loss_o = q.defect;
	assign perf_snapshot_tick_o = q.tick_q;
	assign wan_irq_out_a_o = (q.dpend & q.mask[wpc_pkg::MASK_DA]) | (q.spend & q.mask[wpc_pkg::MASK_SA]); // R3 R15
	assign wan_irq_out_b_o = (q.dpend & q.mask[wpc_pkg::MASK_DB]) | (q.spend & q.mask[wpc_pkg::MASK_SB]); // R3 R15

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	default clocking cb @(posedge mclk_i); endclocking
	default disable iff (!rst_n);

	sequence s_ctrl_force;
		psel_i && penable_i && pwrite_i && paddr_i == wpc_pkg::ADDR_CTRL && pwdata_i[0];
	endsequence

	property p_octet_ab;
		psel_i && penable_i && pwrite_i && paddr_i == wpc_pkg::ADDR_TXOH |=>
			tx_path_growth_octet_a_o == $past(pwdata_i[7:0]) && tx_path_growth_octet_b_o == $past(pwdata_i[15:8]);
	endproperty
	a_octet_ab: assert property (p_octet_ab) else $error("growth octets not updated"); // R1

	property p_octet_n;
		psel_i && penable_i && pwrite_i && paddr_i == wpc_pkg::ADDR_TXOH |=>
			tx_path_data_channel_octet_o == $past(pwdata_i[23:16]);
	endproperty
	a_octet_n: assert property (p_octet_n) else $error("data channel octet not updated"); // R2

	property p_latch;
		pcs_delineation_lost_i |=> q.lat;
	endproperty
	a_latch: assert property (p_latch) else $error("loss status not latched"); // R3

	property p_set;
		$rose(path_delineation_loss_o) |-> $past(q.dcnt) == 32'(SET_CYC) && $past(pcs_delineation_lost_i);
	endproperty
	a_set: assert property (p_set) else $error("defect set without qualification"); // R4

	property p_hold;
		path_delineation_loss_o && !(q.dcnt == 32'(CLR_CYC - 1) && !pcs_delineation_lost_i) |=> path_delineation_loss_o;
	endproperty
	a_hold: assert property (p_hold) else $error("defect dropped early"); // R5

	property p_clr;
		$fell(path_delineation_loss_o) |-> $past(q.dcnt) == 32'(CLR_CYC - 1) && !$past(pcs_delineation_lost_i);
	endproperty
	a_clr: assert property (p_clr) else $error("defect cleared without qualification"); // R6

	property p_upper;
		psel_i && !penable_i && !pwrite_i && paddr_i == wpc_pkg::ADDR_STD |=>
			q.std_hold[0] == $past(q.std_live[0]) && prdata_o[15:0] == $past(q.std_live[0][31:16]);
	endproperty
	a_upper: assert property (p_upper) else $error("upper read did not latch"); // R8

	property p_snap;
		tick |=> q.stat_snap[1] == $past(q.stat_live[1]) && q.stat_live[1] == $past(add[1]) && perf_snapshot_tick_o;
	endproperty
	a_snap: assert property (p_snap) else $error("snapshot not taken"); // R11

	property p_force;
		s_ctrl_force |=> tick ##1 !q.force_p;
	endproperty
	a_force: assert property (p_force) else $error("force did not pulse one tick"); // R12

	property p_sat;
		q.stat_live[1] == 32'hFFFFFFFF && !tick |=> q.stat_live[1] == 32'hFFFFFFFF;
	endproperty
	a_sat: assert property (p_sat) else $error("statistical counter wrapped"); // R16

	property p_pend;
		tick |=> q.spend ##1 (q.spend || $past(rd_status));
	endproperty
	a_pend: assert property (p_pend) else $error("tick pending lost"); // R15

	property p_period;
		q.en && q.src && q.tmr + 32'h1 >= q.period |=> perf_snapshot_tick_o && q.tmr == 32'h0;
	endproperty
	a_period: assert property (p_period) else $error("periodic tick missing"); // R13

	property p_gpio;
		q.en && !q.src && q.gsync[2] && q.gsync[1] && !q.glvl |=> perf_snapshot_tick_o && q.glvl;
	endproperty
	a_gpio: assert property (p_gpio) else $error("gpio edge gave no tick"); // R14

	property p_gpio_once;
		q.glvl && q.gsync[2] && q.gsync[1] && !q.force_p && !(q.en && q.src) |=> !perf_snapshot_tick_o;
	endproperty
	a_gpio_once: assert property (p_gpio_once) else $error("steady gpio level gave a tick"); // R22

	property p_bit_count;
		frame_valid_i && !q.cfg[1] |=>
			q.std_live[1] - $past(q.std_live[1]) == {21'h0, $past(line_parity_mismatch_i)};
	endproperty
	a_bit_count: assert property (p_bit_count) else $error("bit mode count wrong"); // R18

	property p_block_count;
		frame_valid_i && q.cfg[0] |=>
			q.std_live[0] - $past(q.std_live[0]) == {31'h0, $past(section_parity_mismatch_i) != 4'h0};
	endproperty
	a_block_count: assert property (p_block_count) else $error("block mode count wrong"); // R19

endmodule

`default_nettype wire

// ### verification/tb_wis_path_overhead_and_perf_counters.sv
/*
 * tb_wis_path_overhead_and_perf_counters: self-checking bench for wpc_top.
 * assumes: zero-wait APB slave, short loss timers (12 set, 4 clear).
 */
`timescale 1ns/1ps
`default_nettype none

module tb_wis_path_overhead_and_perf_counters;
	logic clk = 0, rst_n = 0, psel = 0, penable = 0, pwrite = 0, lost = 0, gpio = 0, freq = 0;
	logic [7:0] paddr = 0;
	logic [31:0] pwdata = 0, d, lo;
	logic [33:0] fcnt = 0;
	logic [3:0] cfg, c;
	wire logic fv, pready, pslverr, dfc, tick, ia, ib;
	wire logic [33:0] fe;
	wire logic [31:0] prdata;
	wire logic [7:0] oa, ob, on;
	logic [31:0] expq[$];
	logic [31:0] std_m[5], stat_m[5];
	int num_errors = 0, check_count = 0, cyc = 0, ticks = 0, t0, n;

	wpc_far_model u_far (.mclk_i(clk), .rst_n_i(rst_n), .frame_req_i(freq), .counts_i(fcnt),
		.frame_valid_o(fv), .counts_o(fe));

	wpc_top #(.SET_CYC(12), .CLR_CYC(4)) u_dut (.mclk_i(clk), .rst_n_i(rst_n), .psel_i(psel),
		.penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata),
		.prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr), .frame_valid_i(fv),
		.section_parity_mismatch_i(fe[3:0]), .line_parity_mismatch_i(fe[14:4]),
		.path_parity_mismatch_i(fe[18:15]), .far_path_errors_i(fe[22:19]),
		.far_line_errors_i(fe[33:23]), .pcs_delineation_lost_i(lost), .snapshot_gpio_i(gpio),
		.tx_path_growth_octet_a_o(oa), .tx_path_growth_octet_b_o(ob),
		.tx_path_data_channel_octet_o(on), .path_delineation_loss_o(dfc),
		.perf_snapshot_tick_o(tick), .wan_irq_out_a_o(ia), .wan_irq_out_b_o(ib));

	initial forever #12.5 clk = ~clk;

	// ----------------------------------------------------------------
	// checking
	// ----------------------------------------------------------------
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		check_count++;
		if (got !== exp) begin
			num_errors++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task finish_test();
		$display("errors %0d checks %0d", num_errors, check_count);
		if (num_errors == 0 && check_count > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask

	// read results are taken off the queue at the access edge
	always @(posedge clk) begin
		cyc++;
		if (tick === 1'b1)
			ticks++;
		if (psel && penable && pready === 1'b1 && !pwrite)
			chk(prdata, expq.pop_front());
		if (cyc == 20000) begin
			num_errors++;
			finish_test();
		end
	end

	// ----------------------------------------------------------------
	// stimulus
	// ----------------------------------------------------------------
	// for reads dd is the expected data
	task apb(input logic w, input logic [7:0] a, input logic [31:0] dd, input logic err);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= dd;
		if (!w)
			expq.push_back(err ? 32'h0 : dd);
		@(posedge clk);
		chk({31'h0, pready}, 32'h0);
		penable <= 1'b1;
		@(posedge clk);
		while (pready !== 1'b1)
			@(posedge clk);
		chk({31'h0, pslverr}, {31'h0, err});
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge clk);
	endtask

	task frame();
		logic [31:0] v[5];
		logic [31:0] inc;
		v[0] = $urandom_range(8);
		v[1] = $urandom_range(1536);
		v[2] = $urandom_range(8);
		v[3] = $urandom_range(8);
		v[4] = $urandom_range(1536);
		for (int i = 0; i < 5; i++) begin
			inc = (i < 4 && cfg[i]) ? {31'h0, v[i] != 0} : v[i];
			std_m[i] += inc;
			stat_m[i] += inc;
		end
		fcnt <= {v[4][10:0], v[3][3:0], v[2][3:0], v[1][10:0], v[0][3:0]};
		freq <= 1'b1;
		@(posedge clk);
		freq <= 1'b0;
		repeat (3) @(posedge clk);
	endtask

	initial begin
		void'($urandom(32'h5dfb56e3));
		std_m = '{default: 32'h0};
		stat_m = '{default: 32'h0};
		repeat (2) @(posedge clk);
		rst_n <= 1'b1;
		repeat (2) @(posedge clk);
		@(negedge clk);
		chk({31'h0, dfc}, 32'h1);
		chk({8'h0, on, ob, oa}, 32'h0);
		@(posedge clk);
		apb(1'b0, wpc_pkg::ADDR_PERIOD, wpc_pkg::PERIOD_RST, 1'b0);
		repeat (12) @(posedge clk);
		@(negedge clk);
		chk({31'h0, dfc}, 32'h0);
		@(posedge clk);
		apb(1'b1, wpc_pkg::ADDR_MASK, 32'h9, 1'b0);
		lost <= 1'b1;
		repeat (8) @(posedge clk);
		lost <= 1'b0;
		@(negedge clk);
		chk({30'h0, ia, dfc}, 32'h2);
		@(posedge clk);
		lost <= 1'b1;
		repeat (16) @(posedge clk);
		lost <= 1'b0;
		repeat (2) @(posedge clk);
		@(negedge clk);
		chk({31'h0, dfc}, 32'h1);
		repeat (10) @(negedge clk);
		chk({31'h0, dfc}, 32'h0);
		@(posedge clk);
		apb(1'b0, wpc_pkg::ADDR_STATUS, 32'h3, 1'b0);
		apb(1'b0, wpc_pkg::ADDR_STATUS, 32'h0, 1'b0);
		chk({31'h0, ia}, 32'h0);
		apb(1'b0, 8'hFC, 32'h0, 1'b1);
		apb(1'b1, 8'hFC, 32'h0, 1'b1);
		d = $urandom & 32'hFFFFFF;
		apb(1'b1, wpc_pkg::ADDR_TXOH, d, 1'b0);
		apb(1'b0, wpc_pkg::ADDR_TXOH, d, 1'b0);
		chk({8'h0, on, ob, oa}, d);
		c = 4'($urandom);
		for (int k = 0; k < 2; k++) begin
			cfg = k ? ~c : c;
			apb(1'b1, wpc_pkg::ADDR_CFG, {28'h0, cfg}, 1'b0);
			repeat (3) frame();
			t0 = ticks;
			apb(1'b1, wpc_pkg::ADDR_CTRL, 32'h1, 1'b0);
			repeat (4) @(negedge clk);
			chk(32'(ticks - t0), 32'h1);
			@(posedge clk);
			for (int i = 0; i < 5; i++) begin
				apb(1'b0, 8'(wpc_pkg::ADDR_STAT + 4 * i), stat_m[i], 1'b0);
				stat_m[i] = 32'h0;
			end
			for (int i = 0; i < 5; i++) begin
				lo = {16'h0, std_m[i][15:0]};
				apb(1'b0, 8'(wpc_pkg::ADDR_STD + 8 * i), {16'h0, std_m[i][31:16]}, 1'b0);
				frame();
				apb(1'b0, 8'(wpc_pkg::ADDR_STD + 8 * i + 4), lo, 1'b0);
			end
		end
		chk({31'h0, ib}, 32'h1);
		apb(1'b0, wpc_pkg::ADDR_STATUS, 32'h4, 1'b0);
		apb(1'b1, wpc_pkg::ADDR_PERIOD, 32'h5, 1'b0);
		apb(1'b1, wpc_pkg::ADDR_CTRL, 32'h6, 1'b0);
		do @(negedge clk); while (tick !== 1'b1);
		n = 0;
		do begin
			@(negedge clk);
			n++;
		end while (tick !== 1'b1);
		chk(32'(n), 32'h5);
		@(posedge clk);
		apb(1'b1, wpc_pkg::ADDR_CTRL, 32'h2, 1'b0);
		repeat (8) @(posedge clk);
		t0 = ticks;
		repeat (3) begin
			gpio <= 1'b1;
			repeat (6) @(posedge clk);
			gpio <= 1'b0;
			repeat (6) @(posedge clk);
		end
		@(negedge clk);
		chk(32'(ticks - t0), 32'h3);
		finish_test();
	end
endmodule

`default_nettype wire

// ### verification/wpc_far_model.sv
/*
 * wpc_far_model: receive framer stand-in that hands per-frame parity and
 * far-end error counts to the block.
 * assumes: one request pulse per frame from the bench, on mclk_i.
 */
`timescale 1ns/1ps
`default_nettype none

module wpc_far_model (
	// clock and reset
	input wire logic mclk_i,
	input wire logic rst_n_i,
	// frame request from the bench
	input wire logic frame_req_i,
	input wire logic [33:0] counts_i,
	// frame to the block
	output logic frame_valid_o,
	output logic [33:0] counts_o
);
	// between frames the error lines toggle, so only the valid cycle means anything
	always_ff @(posedge mclk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			frame_valid_o <= 1'b0;
			counts_o <= 34'h0;
		end else begin
			frame_valid_o <= frame_req_i;
			counts_o <= frame_req_i ? counts_i : ~counts_o;
		end
	end
endmodule

`default_nettype wire
